// *** fcm_pkg.sv ***
package fcm_pkg;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [15:0] FCM_MODE_SEL_ADDR = 16'hff0f; // i/o space
    localparam logic [15:0] FCM_SEG_CTL_ADDR  = 16'h0000; // program space

    // ------------------------------------------------------------
    // segment control field layout
    // ------------------------------------------------------------
    localparam int FCM_SEG_EN_HI  = 15;
    localparam int FCM_SEG_EN_LO  = 8;
    localparam int FCM_RSVD_BIT   = 7;
    localparam int FCM_KEY_HI     = 6;
    localparam int FCM_KEY_LO     = 5;
    localparam int FCM_VER_HI     = 4;
    localparam int FCM_VER_LO     = 3;
    localparam int FCM_WE_HI      = 2;
    localparam int FCM_WE_LO      = 1;
    localparam int FCM_EXE_BIT    = 0;

    // writable bits of the segment control word (bit 7 reserved)
    localparam logic [15:0] FCM_SEG_CTL_MASK  = 16'hff7f;
    localparam logic [15:0] FCM_SEG_CTL_RESET = 16'h0000;
    // value returned on a mode-select read (content undefined)
    localparam logic [15:0] FCM_MODE_RD_VAL   = 16'h0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    // flash access mode, gray coded
    typedef enum logic [0:0] {
        FCM_ARRAY_MODE = 1'b0,
        FCM_REG_MODE   = 1'b1
    } fcm_mode_t;

    // one processor bus access
    typedef struct packed {
        logic        io_rd;   // i/o space read strobe
        logic        io_wr;   // i/o space write strobe
        logic        pm_rd;   // program space read strobe
        logic        pm_wr;   // program space write strobe
        logic [15:0] addr;    // address
        logic [15:0] wdata;   // write data
    } fcm_req_t;

    // segment control fields
    typedef struct packed {
        logic [7:0] seg_en;
        logic [1:0] key;
        logic [1:0] verify;
        logic [1:0] wr_erase;
        logic       execute;
    } fcm_seg_t;

endpackage : fcm_pkg

// *** fcm_seg_reg.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// segment control register storage, one flop per bit, masked bits never load
// ----------------------------------------------------------------
module fcm_seg_reg #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_nrst,
    // write port
    input  wire logic         i_we,
    input  wire logic [W-1:0] i_wdata,
    input  wire logic [W-1:0] i_mask,
    // stored value
    output logic      [W-1:0] o_q
);

    logic [W-1:0] q_ff;  // stored bits

    // ------------------------------------------------------------
    // per-bit storage
    // ------------------------------------------------------------
    for (genvar b = 0; b < W; b++) begin : g_bit
        // writable bits load on write, reserved bits stay zero
        always_ff @(posedge i_ref_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                q_ff[b] <= 1'b0;
            end else if (i_we && i_mask[b]) begin
                q_ff[b] <= i_wdata[b];
            end
        end
    end

    assign o_q = q_ff;

endmodule : fcm_seg_reg

// *** fcm_flash_mode_ctl.sv ***
`timescale 1ns/10ps
// Behaviour
// - any i/o write to mode select enters register mode
// - i/o read of mode select with no write beside it enters array mode
// - segment control visible only in register mode
// - segment control decoded at program address zero
// - upper byte segment enables, bit 7 reserved
// - key, verify, write/erase, execute in low bits
// - defined fields read/write, reset to zero
// - mode select has no stored content
module fcm_flash_mode_ctl (
    // clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_nrst,
    // processor access
    input  wire fcm_pkg::fcm_req_t i_req,
    // flash array read data for program space
    input  wire logic [15:0]       i_array_rdata,
    // read data back to processor
    output logic      [15:0]       o_rdata,
    // mode and segment control to the flash core
    output logic                   o_reg_mode,
    output fcm_pkg::fcm_seg_t      o_seg
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_ff;  // reset release pipeline
    logic       rst_n;        // synchronised reset

    // two flops release reset cleanly
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_ff[1];

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    fcm_pkg::fcm_mode_t mode_ff;      // current access mode
    fcm_pkg::fcm_mode_t nxt_mode;     // next access mode
    logic               mode_hit;     // address is mode select
    logic               seg_hit;      // address is segment control
    logic               seg_vis;      // segment control visible
    logic               seg_we;       // segment control write
    logic [15:0]        seg_q;        // stored segment control
    logic [15:0]        nxt_rdata;    // read data next value
    logic [15:0]        rdata_ff;     // registered read data

    assign mode_hit = (i_req.addr == fcm_pkg::FCM_MODE_SEL_ADDR);
    assign seg_hit  = (i_req.addr == fcm_pkg::FCM_SEG_CTL_ADDR);
    assign seg_vis  = seg_hit && (mode_ff == fcm_pkg::FCM_REG_MODE);
    assign seg_we   = i_req.pm_wr && seg_vis;

    // mode transitions: write selects register, read selects array
    assign nxt_mode =
        (i_req.io_wr && mode_hit) ? fcm_pkg::FCM_REG_MODE :
        (i_req.io_rd && mode_hit) ? fcm_pkg::FCM_ARRAY_MODE :
        mode_ff;

    // ------------------------------------------------------------
    // mode register
    // ------------------------------------------------------------
    // reset to array mode so the flash fetches code
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= fcm_pkg::FCM_ARRAY_MODE;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ------------------------------------------------------------
    // segment control storage
    // ------------------------------------------------------------
    fcm_seg_reg #(
        .W (16)
    ) u_seg (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (rst_n),
        .i_we      (seg_we),
        .i_wdata   (i_req.wdata),
        .i_mask    (fcm_pkg::FCM_SEG_CTL_MASK),
        .o_q       (seg_q)
    );

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // mode select has no content: fixed value returned
    assign nxt_rdata =
        (i_req.io_rd && mode_hit) ? fcm_pkg::FCM_MODE_RD_VAL :
        (i_req.pm_rd && seg_vis)  ? seg_q :
        i_req.pm_rd               ? i_array_rdata :
        rdata_ff;

    // read data held until the next program read or mode select read
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_rdata           = rdata_ff;
    assign o_reg_mode        = (mode_ff == fcm_pkg::FCM_REG_MODE);
    // field split of the stored word
    assign o_seg.seg_en      = seg_q[fcm_pkg::FCM_SEG_EN_HI:
                                     fcm_pkg::FCM_SEG_EN_LO];
    assign o_seg.key         = seg_q[fcm_pkg::FCM_KEY_HI:
                                     fcm_pkg::FCM_KEY_LO];
    assign o_seg.verify      = seg_q[fcm_pkg::FCM_VER_HI:
                                     fcm_pkg::FCM_VER_LO];
    assign o_seg.wr_erase    = seg_q[fcm_pkg::FCM_WE_HI:
                                     fcm_pkg::FCM_WE_LO];
    assign o_seg.execute     = seg_q[fcm_pkg::FCM_EXE_BIT];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // mode select write enters register mode, also with a read beside it
    mode_write_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_req.io_wr && mode_hit) |=> o_reg_mode)
        else $error("mode select write did not enter register mode");

    // mode only moves on a mode select access
    mode_hold_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        !(mode_hit && (i_req.io_wr || i_req.io_rd)) |=> $stable(o_reg_mode))
        else $error("mode changed without a mode select access");

    // plain mode select read returns to array mode
    mode_read_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_req.io_rd && mode_hit && !i_req.io_wr) |=> !o_reg_mode)
        else $error("mode select read did not enter array mode");

    // writes in array mode must not reach the hidden register
    hidden_write_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_req.pm_wr && seg_hit && !o_reg_mode) |=> $stable(seg_q))
        else $error("segment control changed in array mode");

    // reads at address zero in register mode return the stored word
    seg_visible_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_req.pm_rd && seg_vis) |=> o_rdata == $past(seg_q))
        else $error("register mode read did not return segment control");

    // write then read back at address zero
    seg_readback_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_req.pm_wr && seg_hit && o_reg_mode) ##1
        (i_req.pm_rd && seg_hit && o_reg_mode && !i_req.pm_wr) |=>
        o_rdata == ($past(i_req.wdata, 2) & fcm_pkg::FCM_SEG_CTL_MASK))
        else $error("segment control read back wrong");

    // writes to any other program address leave the register alone
    other_addr_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_req.pm_wr && !seg_hit) |=> $stable(seg_q))
        else $error("write elsewhere changed segment control");

    reserved_zero_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        seg_q[fcm_pkg::FCM_RSVD_BIT] == 1'b0)
        else $error("reserved bit 7 set");

    // field checks: every defined field lands where it belongs
    seg_en_field_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        seg_we |=> o_seg.seg_en ==
            $past(i_req.wdata[fcm_pkg::FCM_SEG_EN_HI:fcm_pkg::FCM_SEG_EN_LO]))
        else $error("segment enable field not stored");

    key_field_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        seg_we |=> o_seg.key ==
            $past(i_req.wdata[fcm_pkg::FCM_KEY_HI:fcm_pkg::FCM_KEY_LO]))
        else $error("key field not stored");

    verify_field_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        seg_we |=> o_seg.verify ==
            $past(i_req.wdata[fcm_pkg::FCM_VER_HI:fcm_pkg::FCM_VER_LO]))
        else $error("verify field not stored");

    wr_erase_field_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        seg_we |=> o_seg.wr_erase ==
            $past(i_req.wdata[fcm_pkg::FCM_WE_HI:fcm_pkg::FCM_WE_LO]))
        else $error("write/erase field not stored");

    exe_field_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        seg_we |=> o_seg.execute == $past(i_req.wdata[fcm_pkg::FCM_EXE_BIT]))
        else $error("execute bit not stored");

    // while reset holds, fields are clear and the flash is in array mode
    reset_clear_a: assert property (@(posedge i_ref_clk)
        !rst_n |-> (seg_q == fcm_pkg::FCM_SEG_CTL_RESET) && !o_reg_mode)
        else $error("reset left segment control or mode set");

    mode_rdval_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_req.io_rd && mode_hit) |=> o_rdata == fcm_pkg::FCM_MODE_RD_VAL)
        else $error("mode select read value wrong");

    // array mode reads at address zero come from the flash array
    array_read_a: assert property (
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_req.pm_rd && seg_hit && !o_reg_mode && !i_req.io_rd) |=>
        o_rdata == $past(i_array_rdata))
        else $error("array mode read did not return array data");

endmodule : fcm_flash_mode_ctl

// *** fcm_array_model.sv ***
`timescale 1ns/10ps
// flash array stand-in: each word is derived from its address
module fcm_array_model (
    // program address from the processor
    input  wire logic [15:0] i_addr,
    // array word back to the controller
    output logic      [15:0] o_rdata
);
    // distinct word per address so a wrong read source shows up
    assign o_rdata = {i_addr[7:0], i_addr[15:8]} ^ 16'h3c5a;
endmodule : fcm_array_model

// *** tb_flash_register_mode_control.sv ***
`timescale 1ns/10ps
module tb_flash_register_mode_control;
    logic              i_ref_clk;
    logic              i_nrst;
    fcm_pkg::fcm_req_t req;          // processor access under test
    logic [15:0]       arr;          // array word from the model
    logic [15:0]       o_rdata;
    logic              o_reg_mode;
    fcm_pkg::fcm_seg_t o_seg;
    logic [31:0]       exp_q[$];     // expected {mode, seg, rdata}
    logic [31:0]       e;
    logic              pend;         // an access was taken last edge
    logic              m;            // expected mode
    logic [15:0]       s;            // expected segment control word
    logic [15:0]       r;            // expected read data
    logic [31:0]       rng;
    int                failures;
    int                total_checks;

    fcm_flash_mode_ctl uut (
        .i_ref_clk    (i_ref_clk),
        .i_nrst       (i_nrst),
        .i_req        (req),
        .i_array_rdata(arr),
        .o_rdata      (o_rdata),
        .o_reg_mode   (o_reg_mode),
        .o_seg        (o_seg)
    );
    fcm_array_model flash (.i_addr(req.addr), .o_rdata(arr));

    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    function automatic logic [15:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[15:0];
    endfunction : rnd

    // one access; k is {io_rd, io_wr, pm_rd, pm_wr}
    task automatic acc(input logic [3:0] k, input logic [15:0] a,
                       input logic [15:0] d);
        @(negedge i_ref_clk);
        req = {k, a, d};
        // a mode select read returns the fixed word; a write beside it wins
        if (k[3] && a == fcm_pkg::FCM_MODE_SEL_ADDR) begin
            m = 1'b0;
            r = fcm_pkg::FCM_MODE_RD_VAL;
        end
        if (k[2] && a == fcm_pkg::FCM_MODE_SEL_ADDR) m = 1'b1;
        if (k[0] && m && a == fcm_pkg::FCM_SEG_CTL_ADDR)
            s = d & fcm_pkg::FCM_SEG_CTL_MASK;
        if (k[1]) r = (m && a == fcm_pkg::FCM_SEG_CTL_ADDR) ? s
                    : ({a[7:0], a[15:8]} ^ 16'h3c5a);
        exp_q.push_back({m, s[15:8], s[6:0], r});
    endtask : acc

    task automatic idle(input int n);
        repeat (n) begin
            @(negedge i_ref_clk);
            req = '0;
        end
    endtask : idle

    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // compares outputs one edge after each taken access
    always @(posedge i_ref_clk) begin
        if (pend) begin
            e = exp_q.pop_front();
            total_checks++;
            if ({o_reg_mode, o_seg, o_rdata} !== e) begin
                failures++;
                $display("BAD outputs exp %h seen %h", e,
                         {o_reg_mode, o_seg, o_rdata});
            end
        end
        pend <= (|req[35:32]) && i_nrst;
    end

    initial begin
        #20000;
        failures++;
        final_report();
    end

    initial begin
        req = '0;
        i_nrst = 1'b0;
        rng = 32'h6b41;
        {m, s, r} = '0;
        {failures, total_checks, pend} = '0;
        repeat (6) @(negedge i_ref_clk);
        i_nrst = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        acc(4'h8, 16'h0f0f, 16'h0000);
        acc(4'h2, 16'h0000, 16'h0000);
        acc(4'h1, 16'h0000, 16'hffff);
        acc(4'h2, 16'h0000, 16'h0000);
        acc(4'h4, 16'hff0f, rnd());
        acc(4'h1, 16'h0000, 16'hffff);
        acc(4'h2, 16'h0000, 16'h0000);
        acc(4'h2, 16'h0001, 16'h0000);
        // walking one over every field, then random words
        for (int i = 0; i < 16; i++) begin
            acc(4'h1, 16'h0000, 16'h0001 << i);
            acc(4'h2, 16'h0000, 16'h0000);
        end
        for (int i = 0; i < 8; i++) begin
            acc(4'h1, 16'h0000, rnd());
            acc(4'h2, 16'h0000, 16'h0000);
        end
        acc(4'h8, 16'hff0f, 16'h0000);
        acc(4'h2, 16'h0000, 16'h0000);
        acc(4'h1, 16'h0000, 16'h1234);
        acc(4'h4, 16'h0f0f, rnd());
        acc(4'h2, 16'h0000, 16'h0000);
        acc(4'h4, 16'hff0f, rnd());
        acc(4'h2, 16'h0000, 16'h0000);
        acc(4'hc, 16'hff0f, rnd());
        acc(4'h1, 16'h0001, rnd());
        acc(4'h2, 16'h0000, 16'h0000);
        // reset in mid-run clears mode and fields
        idle(3);
        i_nrst = 1'b0;
        {m, s, r} = '0;
        repeat (2) @(negedge i_ref_clk);
        i_nrst = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        acc(4'h4, 16'hff0f, rnd());
        acc(4'h2, 16'h0000, 16'h0000);
        acc(4'h1, 16'h0000, rnd());
        acc(4'h2, 16'h0000, 16'h0000);
        idle(3);
        final_report();
    end
endmodule : tb_flash_register_mode_control
